// ### gcr_global_config_register0.sv
// Global configuration register 0, both security banks, on AHB-Lite.
`timescale 1ns/100ps

module gcr_global_config_register0 #(
   parameter bit TRANSIENT_PRESENT = 1'b1,
   parameter bit CFG_FAULTS_SUPPORTED = 1'b1,
   parameter bit EXT_ID_SUPPORTED = 1'b1,
   parameter bit STREAM_MATCH_SUPPORTED = 1'b1,
   parameter bit WIDE_VM_ID_SUPPORTED = 1'b1,
   parameter bit HOST_EXT_SUPPORTED = 1'b1,
   parameter bit WRITE_ALLOC_SUPPORTED = 1'b1,
   parameter bit READ_ALLOC_SUPPORTED = 1'b1,
   parameter bit SHARE_SUPPORTED = 1'b1,
   parameter bit MULTI_MATCH_CONFIGURABLE = 1'b1,
   parameter bit MULTI_MATCH_FIXED_VALUE = 1'b0,
   parameter bit BARRIER_UPGRADE_SUPPORTED = 1'b1,
   parameter bit BROADCAST_TLB_SUPPORTED = 1'b1,
   parameter bit PRIVATE_TLB_SUPPORTED = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire gcr_pkg::gcr_event_t faultEvt,
   input wire logic tlbMaintDone,
   output gcr_pkg::gcr_resp_t faultResp,
   output gcr_pkg::gcr_bypass_t bypassAttr,
   output gcr_pkg::gcr_ctrl_t ctrl
);

   ////////////////////////////////////////////////////////////////////////////

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WRITE = 4'b0010,
      ST_RDWAIT = 4'b0100,
      ST_RDOUT = 4'b1000
   } gcr_bus_state_t;

   gcr_bus_state_t state_q;
   gcr_bus_state_t state_d;
   logic [gcr_pkg::ADDR_BITS-1:0] addr_q;
   logic [31:0] hrdata_q;
   logic accept;
   logic writeNow;
   logic [31:0] readMux;
   logic [31:0] secRead;
   logic [31:0] nsecRead;
   logic [31:0] statRead;
   logic secWr;
   logic nsecWr;

   logic [1:0] transient_q;
   logic cfgIrqEn_q;
   logic cfgAbortEn_q;
   logic extIdEn_q;
   logic glbIrqEn_q;
   logic glbAbortEn_q;
   logic client_port_disable_q;
   logic wideVmId_q;
   logic hypSel_q;
   logic [1:0] writeAlloc_q;
   logic [1:0] readAlloc_q;
   logic [1:0] share_q;
   logic multiMatch_q;
   logic memTypeOvr_q;
   logic [3:0] bypass_mem_attr_q;
   logic [1:0] barrier_q;
   logic forceBcast_q;
   logic privTlb_q;
   logic tlbPend_q;
   gcr_pkg::gcr_resp_t resp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave. Reads take one wait state so that a read right after a write
   // sees the written value from a registered data path.

   assign accept = hsel && hready && htrans == gcr_pkg::HTRANS_NONSEQ;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE, ST_WRITE, ST_RDOUT: begin
            if (accept && hwrite) begin
               state_d = ST_WRITE;
            end else if (accept) begin
               state_d = ST_RDWAIT;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_RDWAIT: begin
            state_d = ST_RDOUT;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_q <= '0;
      end else if (accept) begin
         addr_q <= haddr[gcr_pkg::ADDR_BITS-1:0];
      end
   end

   assign hreadyout = state_q != ST_RDWAIT;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign writeNow = state_q == ST_WRITE;
   assign secWr = writeNow && addr_q == gcr_pkg::SEC_CFG0_OFFSET;
   assign nsecWr = writeNow && addr_q == gcr_pkg::NSEC_CFG0_OFFSET;

   always_comb begin
      secRead = '0;
      secRead[gcr_pkg::TRANSIENT_LSB +: 2] = transient_q;
      secRead[gcr_pkg::CFG_FAULT_IRQ_BIT] = cfgIrqEn_q;
      secRead[gcr_pkg::CFG_FAULT_ABORT_BIT] = cfgAbortEn_q;
      secRead[gcr_pkg::EXT_ID_BIT] = extIdEn_q;
      secRead[gcr_pkg::GLOBAL_IRQ_BIT] = glbIrqEn_q;
      secRead[gcr_pkg::GLOBAL_ABORT_BIT] = glbAbortEn_q;
      secRead[gcr_pkg::CLIENT_PD_BIT] = client_port_disable_q;
      nsecRead = '0;
      nsecRead[gcr_pkg::WIDE_VM_TAG_BIT] = wideVmId_q;
      nsecRead[gcr_pkg::HYP_SEL_BIT] = hypSel_q;
      nsecRead[gcr_pkg::WRITE_ALLOC_LSB +: 2] = writeAlloc_q;
      nsecRead[gcr_pkg::READ_ALLOC_LSB +: 2] = readAlloc_q;
      nsecRead[gcr_pkg::SHARE_LSB +: 2] = share_q;
      nsecRead[gcr_pkg::MULTI_MATCH_BIT] = multiMatch_q;
      nsecRead[gcr_pkg::MEMTYPE_OVR_BIT] = memTypeOvr_q;
      nsecRead[gcr_pkg::MEM_ATTR_LSB +: 4] = bypass_mem_attr_q;
      nsecRead[gcr_pkg::BARRIER_LSB +: 2] = barrier_q;
      nsecRead[gcr_pkg::FORCE_BCAST_BIT] = forceBcast_q;
      nsecRead[gcr_pkg::PRIVATE_TLB_BIT] = privTlb_q;
      statRead = '0;
      statRead[gcr_pkg::TLB_MAINT_PEND_BIT] = tlbPend_q;
   end

   always_comb begin
      unique case (addr_q)
         gcr_pkg::SEC_CFG0_OFFSET: readMux = secRead;
         gcr_pkg::NSEC_CFG0_OFFSET: readMux = nsecRead;
         gcr_pkg::STATUS_OFFSET: readMux = statRead;
         default: readMux = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hrdata_q <= '0;
      end else if (state_q == ST_RDWAIT) begin
         hrdata_q <= readMux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Secure bank, bits 7 down to 0. Absent features are held at zero so
   // that they read as zero and writes never reach them.

   always_ff @(posedge core_clk) begin
      if (rst) begin
         transient_q <= gcr_pkg::HINT_RESET;
      end else if (secWr && TRANSIENT_PRESENT) begin
         transient_q <= hwdata[gcr_pkg::TRANSIENT_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfgIrqEn_q <= gcr_pkg::FLAG_RESET;
         cfgAbortEn_q <= gcr_pkg::FLAG_RESET;
      end else if (secWr && CFG_FAULTS_SUPPORTED) begin
         cfgIrqEn_q <= hwdata[gcr_pkg::CFG_FAULT_IRQ_BIT];
         cfgAbortEn_q <= hwdata[gcr_pkg::CFG_FAULT_ABORT_BIT];
      end
   end

   // Software must quiesce the match groups before flipping this bit; the
   // hardware takes the write as given and does not check them.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         extIdEn_q <= gcr_pkg::FLAG_RESET;
      end else if (secWr && EXT_ID_SUPPORTED && STREAM_MATCH_SUPPORTED) begin
         extIdEn_q <= hwdata[gcr_pkg::EXT_ID_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         glbIrqEn_q <= gcr_pkg::FLAG_RESET;
         glbAbortEn_q <= gcr_pkg::FLAG_RESET;
         client_port_disable_q <= gcr_pkg::CLIENT_PD_RESET;
      end else if (secWr) begin
         glbIrqEn_q <= hwdata[gcr_pkg::GLOBAL_IRQ_BIT];
         glbAbortEn_q <= hwdata[gcr_pkg::GLOBAL_ABORT_BIT];
         client_port_disable_q <= hwdata[gcr_pkg::CLIENT_PD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Non-secure bank, bits 31 down to 12.

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wideVmId_q <= gcr_pkg::FLAG_RESET;
      end else if (nsecWr && WIDE_VM_ID_SUPPORTED) begin
         wideVmId_q <= hwdata[gcr_pkg::WIDE_VM_TAG_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hypSel_q <= gcr_pkg::FLAG_RESET;
      end else if (nsecWr && HOST_EXT_SUPPORTED) begin
         hypSel_q <= hwdata[gcr_pkg::HYP_SEL_BIT];
      end
   end

   // A change of context selection leaves stale TLB entries behind; the
   // pending flag shows it until maintenance is reported done. Set wins.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tlbPend_q <= 1'b0;
      end else if (nsecWr && HOST_EXT_SUPPORTED
                   && hwdata[gcr_pkg::HYP_SEL_BIT] != hypSel_q) begin
         tlbPend_q <= 1'b1;
      end else if (tlbMaintDone) begin
         tlbPend_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         writeAlloc_q <= gcr_pkg::HINT_RESET;
      end else if (nsecWr && WRITE_ALLOC_SUPPORTED) begin
         writeAlloc_q <= hwdata[gcr_pkg::WRITE_ALLOC_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         readAlloc_q <= gcr_pkg::HINT_RESET;
      end else if (nsecWr && READ_ALLOC_SUPPORTED) begin
         readAlloc_q <= hwdata[gcr_pkg::READ_ALLOC_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         share_q <= gcr_pkg::HINT_RESET;
      end else if (nsecWr && SHARE_SUPPORTED) begin
         share_q <= hwdata[gcr_pkg::SHARE_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         multiMatch_q <= MULTI_MATCH_CONFIGURABLE ? gcr_pkg::FLAG_RESET
                                                  : MULTI_MATCH_FIXED_VALUE;
      end else if (nsecWr && MULTI_MATCH_CONFIGURABLE) begin
         multiMatch_q <= hwdata[gcr_pkg::MULTI_MATCH_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         memTypeOvr_q <= gcr_pkg::FLAG_RESET;
         bypass_mem_attr_q <= gcr_pkg::MEM_ATTR_RESET;
         forceBcast_q <= gcr_pkg::FLAG_RESET;
      end else if (nsecWr) begin
         memTypeOvr_q <= hwdata[gcr_pkg::MEMTYPE_OVR_BIT];
         bypass_mem_attr_q <= hwdata[gcr_pkg::MEM_ATTR_LSB +: 4];
         forceBcast_q <= hwdata[gcr_pkg::FORCE_BCAST_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         barrier_q <= gcr_pkg::HINT_RESET;
      end else if (nsecWr && BARRIER_UPGRADE_SUPPORTED) begin
         barrier_q <= hwdata[gcr_pkg::BARRIER_LSB +: 2];
      end
   end

   // Without broadcast maintenance the TLBs are private anyway, so the hint
   // reads one; with it but no private mode, the hint reads zero.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         privTlb_q <= !BROADCAST_TLB_SUPPORTED;
      end else if (nsecWr && BROADCAST_TLB_SUPPORTED
                   && PRIVATE_TLB_SUPPORTED) begin
         privTlb_q <= hwdata[gcr_pkg::PRIVATE_TLB_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault handling driven by the enables; responses are registered pulses.

   always_ff @(posedge core_clk) begin
      if (rst) begin
         resp_q <= '0;
      end else begin
         resp_q.globalFaultIrq <= faultEvt.globalFault && glbIrqEn_q;
         resp_q.configFaultIrq <= faultEvt.configFault && cfgIrqEn_q;
         resp_q.abortResp <= (faultEvt.globalFault && glbAbortEn_q)
                             || (faultEvt.configFault && cfgAbortEn_q);
         resp_q.exclusiveFail <= faultEvt.globalFault && faultEvt.exclusive
                                 && !glbAbortEn_q;
         resp_q.matchConflictFault <= faultEvt.multiMatch && multiMatch_q;
         resp_q.matchBypass <= faultEvt.multiMatch && !multiMatch_q;
      end
   end

   assign faultResp = resp_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bypassAttr <= '0;
         ctrl <= '0;
      end else begin
         bypassAttr.transientHint <= transient_q;
         bypassAttr.writeAllocHint <= writeAlloc_q;
         bypassAttr.readAllocHint <= readAlloc_q;
         bypassAttr.shareAttr <= share_q;
         bypassAttr.memTypeOverride <= memTypeOvr_q;
         bypassAttr.bypass_mem_attr <= memTypeOvr_q ? bypass_mem_attr_q : 4'h0;
         bypassAttr.barrierUpgrade <= barrier_q;
         ctrl.clientPortDisable <= client_port_disable_q;
         ctrl.extStreamIdEn <= extIdEn_q;
         ctrl.wideVmIdEn <= wideVmId_q;
         ctrl.hypCtxSelect <= hypSel_q;
         ctrl.forceBroadcastMaint <= forceBcast_q;
         ctrl.privateTlbMaint <= privTlb_q;
         ctrl.multiMatchFaultCfg <= multiMatch_q;
      end
   end

endmodule : gcr_global_config_register0

// ### gcr_global_config_register0_properties.sv
// Checker for bus timing and fault responses of config register 0.
`timescale 1ns/100ps

module gcr_global_config_register0_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire gcr_pkg::gcr_event_t faultEvt,
   input wire logic tlbMaintDone,
   input wire gcr_pkg::gcr_resp_t faultResp,
   input wire gcr_pkg::gcr_bypass_t bypassAttr,
   input wire gcr_pkg::gcr_ctrl_t ctrl
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence readTaken;
      hsel && hready && htrans == gcr_pkg::HTRANS_NONSEQ && !hwrite;
   endsequence
   sequence writeTaken;
      hsel && hready && htrans == gcr_pkg::HTRANS_NONSEQ && hwrite;
   endsequence
   sequence readWait;
      !hreadyout ##1 hreadyout;
   endsequence

   ////////////////////////////////////////////////////////////
   AST_OKAY_ONLY:
   assert property (hresp == 1'b0) else $error("Error response seen.");
   AST_READ_WAIT:
   assert property (readTaken |=> readWait)
      else $error("Read data phase timing wrong.");
   AST_WRITE_NO_WAIT:
   assert property (writeTaken |=> hreadyout)
      else $error("Write data phase stalled.");
   AST_RESET_STATE:
   assert property ($fell(rst) |-> (faultResp == '0 && bypassAttr == '0)
      ##1 ctrl.clientPortDisable) else $error("Bad state after reset.");
   AST_GLOBAL_IRQ_CAUSE:
   assert property (faultResp.globalFaultIrq |-> $past(faultEvt.globalFault))
      else $error("Global fault interrupt without fault.");
   AST_CFG_IRQ_CAUSE:
   assert property (faultResp.configFaultIrq |-> $past(faultEvt.configFault))
      else $error("Config fault interrupt without fault.");
   AST_ABORT_CAUSE:
   assert property (!faultEvt.globalFault && !faultEvt.configFault
      |=> !faultResp.abortResp) else $error("Abort without fault.");
   AST_EXCL_FAIL_CAUSE:
   assert property (faultResp.exclusiveFail |->
      $past(faultEvt.globalFault) && $past(faultEvt.exclusive))
      else $error("Exclusive failure without cause.");
   AST_MATCH_ONE_WAY:
   assert property (faultEvt.multiMatch |=>
      faultResp.matchConflictFault != faultResp.matchBypass)
      else $error("Multi-match answered wrongly.");
   AST_MATCH_CAUSE:
   assert property (faultResp.matchConflictFault || faultResp.matchBypass
      |-> $past(faultEvt.multiMatch)) else $error("Match response uncaused.");
   AST_BYPASS_MEM_ATTR_GATED:
   assert property (!bypassAttr.memTypeOverride |-> bypassAttr.bypass_mem_attr == 4'h0)
      else $error("Memory attribute leaks without override.");
endmodule : gcr_global_config_register0_properties

bind gcr_global_config_register0 gcr_global_config_register0_properties
   u_props (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .faultEvt(faultEvt), .tlbMaintDone(tlbMaintDone),
   .faultResp(faultResp), .bypassAttr(bypassAttr), .ctrl(ctrl));

// ### gcr_global_config_register0_tb.sv
// Testbench for config register 0: full and stripped-down instances.
`timescale 1ns/100ps

module gcr_global_config_register0_tb;
   localparam logic [11:0] SEC = gcr_pkg::SEC_CFG0_OFFSET;
   localparam logic [11:0] NSEC = gcr_pkg::NSEC_CFG0_OFFSET;
   localparam logic [11:0] STAT = gcr_pkg::STATUS_OFFSET;
   logic core_clk, rst, hsel, hwrite, tlbMaintDone;
   logic [31:0] haddr, hwdata, hrdata, hrdataB, rdA, rdB;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp;
   gcr_pkg::gcr_event_t faultEvt;
   gcr_pkg::gcr_resp_t faultResp;
   gcr_pkg::gcr_bypass_t bypassAttr;
   gcr_pkg::gcr_ctrl_t ctrl;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;

   gcr_global_config_register0 dut (.core_clk(core_clk), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .faultEvt(faultEvt), .tlbMaintDone(tlbMaintDone),
      .faultResp(faultResp), .bypassAttr(bypassAttr), .ctrl(ctrl));

   // Five optional features removed, so their fixed-value paths run too.
   gcr_global_config_register0 #(.TRANSIENT_PRESENT(1'b0),
      .CFG_FAULTS_SUPPORTED(1'b0), .EXT_ID_SUPPORTED(1'b0),
      .SHARE_SUPPORTED(1'b0), .BROADCAST_TLB_SUPPORTED(1'b0))
   dutRaz (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdataB),
      .faultEvt(faultEvt), .tlbMaintDone(tlbMaintDone), .faultResp(),
      .bypassAttr(), .ctrl());

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Both instances share the bus, so one transfer serves them both.
   task automatic ahb_xfer(input logic w, input logic [11:0] a,
                           input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= gcr_pkg::HTRANS_NONSEQ;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rdA = hrdata;
      rdB = hrdataB;
   endtask : ahb_xfer

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] expA,
                         input logic [31:0] expB);
      ahb_xfer(1'b0, a, 32'h0);
      check(rdA, expA);
      check(rdB, expB);
   endtask : rd_chk

   task automatic fault(input logic [3:0] evt, input logic [5:0] exp);
      @(posedge core_clk);
      faultEvt <= gcr_pkg::gcr_event_t'(evt);
      @(posedge core_clk);
      faultEvt <= '0;
      #1;
      check({26'h0, faultResp}, {26'h0, exp});
   endtask : fault

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] f;
      logic [31:0] expRaz;
      rst = 1'b1;
      {hsel, hwrite, tlbMaintDone, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      faultEvt = '0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check(ctrl.clientPortDisable, 1'b1);
      check(bypassAttr, 32'h0);
      rd_chk(SEC, 32'h1, 32'h1);
      rd_chk(NSEC, 32'h0, 32'h1000);
      rd_chk(STAT, 32'h0, 32'h0);
      ahb_xfer(1'b1, SEC, 32'hffffffff);
      rd_chk(SEC, 32'hff, 32'h7);
      check({ctrl.extStreamIdEn, bypassAttr.transientHint}, 3'h7);
      ahb_xfer(1'b1, NSEC, 32'hffffffff);
      rd_chk(NSEC, 32'hcffff000, 32'hcf3ff000);
      check(ctrl, 7'h7f);
      rd_chk(STAT, 32'h1, 32'h1);
      @(posedge core_clk);
      tlbMaintDone <= 1'b1;
      @(posedge core_clk);
      tlbMaintDone <= 1'b0;
      rd_chk(STAT, 32'h0, 32'h0);
      ahb_xfer(1'b1, 12'h0fc, 32'hffffffff);
      rd_chk(12'h0fc, 32'h0, 32'h0);
      rd_chk(SEC, 32'hff, 32'h7);
      for (int v = 0; v < 4; v++) begin
         f = v[1:0];
         ahb_xfer(1'b1, NSEC, {4'h0, f, f, f, 6'h0, f, 14'h0});
         ahb_xfer(1'b1, SEC, {24'h0, f, 6'h1});
         expRaz = {4'h0, f, f, 2'h0, 6'h0, f, 14'h1000};
         rd_chk(NSEC, {4'h0, f, f, f, 6'h0, f, 14'h0}, expRaz);
         check(bypassAttr, {f, f, f, f, 5'h0, f});
      end
      ahb_xfer(1'b1, NSEC, 32'h001a0000);
      rd_chk(NSEC, 32'h001a0000, 32'h001a1000);
      check(bypassAttr.bypass_mem_attr, 4'ha);
      ahb_xfer(1'b1, NSEC, 32'h000a0000);
      rd_chk(NSEC, 32'h000a0000, 32'h000a1000);
      check(bypassAttr.bypass_mem_attr, 4'h0);
      ahb_xfer(1'b1, SEC, 32'h37);
      fault(4'h8, 6'h28);
      fault(4'h4, 6'h18);
      fault(4'h9, 6'h28);
      fault(4'h2, 6'h01);
      ahb_xfer(1'b1, SEC, 32'h1);
      fault(4'h9, 6'h04);
      fault(4'h4, 6'h00);
      ahb_xfer(1'b1, NSEC, 32'h00200000);
      fault(4'h2, 6'h02);
      close_out();
   end
endmodule : gcr_global_config_register0_tb

// ### gcr_pkg.sv
// Package with the map, field layout and reset values of config register 0.
package gcr_pkg;

   localparam logic [11:0] SEC_CFG0_OFFSET = 12'h000;
   localparam logic [11:0] NSEC_CFG0_OFFSET = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;
   localparam int ADDR_BITS = 12;

   // Secure bank fields.
   localparam int TRANSIENT_LSB = 6;
   localparam int CFG_FAULT_IRQ_BIT = 5;
   localparam int CFG_FAULT_ABORT_BIT = 4;
   localparam int EXT_ID_BIT = 3;
   localparam int GLOBAL_IRQ_BIT = 2;
   localparam int GLOBAL_ABORT_BIT = 1;
   localparam int CLIENT_PD_BIT = 0;

   // Non-secure bank fields.
   localparam int WIDE_VM_TAG_BIT = 31;
   localparam int HYP_SEL_BIT = 30;
   localparam int WRITE_ALLOC_LSB = 26;
   localparam int READ_ALLOC_LSB = 24;
   localparam int SHARE_LSB = 22;
   localparam int MULTI_MATCH_BIT = 21;
   localparam int MEMTYPE_OVR_BIT = 20;
   localparam int MEM_ATTR_LSB = 16;
   localparam int BARRIER_LSB = 14;
   localparam int FORCE_BCAST_BIT = 13;
   localparam int PRIVATE_TLB_BIT = 12;

   // Status register fields.
   localparam int TLB_MAINT_PEND_BIT = 0;

   // Reset values; undefined fields are given zero.
   localparam logic [1:0] HINT_RESET = 2'h0;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic CLIENT_PD_RESET = 1'h1;
   localparam logic [3:0] MEM_ATTR_RESET = 4'h0;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic [1:0] transientHint;
      logic [1:0] writeAllocHint;
      logic [1:0] readAllocHint;
      logic [1:0] shareAttr;
      logic memTypeOverride;
      logic [3:0] bypass_mem_attr;
      logic [1:0] barrierUpgrade;
   } gcr_bypass_t;

   typedef struct packed {
      logic clientPortDisable;
      logic extStreamIdEn;
      logic wideVmIdEn;
      logic hypCtxSelect;
      logic forceBroadcastMaint;
      logic privateTlbMaint;
      logic multiMatchFaultCfg;
   } gcr_ctrl_t;

   typedef struct packed {
      logic globalFault;
      logic configFault;
      logic multiMatch;
      logic exclusive;
   } gcr_event_t;

   typedef struct packed {
      logic globalFaultIrq;
      logic configFaultIrq;
      logic abortResp;
      logic exclusiveFail;
      logic matchConflictFault;
      logic matchBypass;
   } gcr_resp_t;

endpackage : gcr_pkg
